// [hdl/ods_consts.svh]
// constants for the optical diode signal conditioning block
`ifndef ODS_CONSTS_SVH
`define ODS_CONSTS_SVH

// converter channels: d1..d4 central, r1 r2 satellite
`define ODS_NUM_CH        6
`define ODS_LVL_W         9
`define ODS_WIN_LAST      8'hFF

// register word indices (byte address = index * 4)
`define ODS_IDX_CTRL      6'h00
`define ODS_IDX_STATUS    6'h01
`define ODS_IDX_MASK      6'h02
`define ODS_IDX_START_THR 6'h03
`define ODS_IDX_DROP_THR  6'h04
`define ODS_IDX_RADIAL_GAIN_COEFF   6'h05
`define ODS_IDX_RADIAL_OFFSET_COEFF 6'h06
`define ODS_IDX_SUM_GAIN  6'h07
`define ODS_IDX_FOCUS_RD  6'h08
`define ODS_IDX_RADIAL_RD 6'h09
`define ODS_IDX_CGAIN     6'h0A
`define ODS_IDX_PID       6'h0B
`define ODS_IDX_SGAIN     6'h0C
`define ODS_IDX_DRIVE_RD  6'h0D

// control register bit positions
`define ODS_CTRL_SINGLE   0
`define ODS_CTRL_CAL      1
`define ODS_CTRL_FOCUS_EN 2
`define ODS_CTRL_CAL_BUSY 3

// status / mask bit positions
`define ODS_EV_FOK_RISE   0
`define ODS_EV_DROPOUT    1
`define ODS_EV_CAL_DONE   2
`define ODS_EV_TRK_LOSS   3

// reset values
`define ODS_RST_GAIN      4'hF
`define ODS_RST_START_THR 11'h200
`define ODS_RST_DROP_THR  11'h100
`define ODS_RST_RADIAL_GAIN_COEFF   8'h10
`define ODS_RST_RADIAL_OFFSET_COEFF 8'h00
`define ODS_RST_SUM_GAIN  8'h20
`define ODS_RST_KP        8'h08
`define ODS_RST_KI        8'h01
`define ODS_RST_KD        8'h04
`define ODS_RST_FE_START  8'h10

// level initialisation
`define ODS_CAL_LAST      4'hF
`define ODS_CAL_SHIFT     4
`define ODS_RE_TARGET     24'h000040

`endif

// [hdl/ods_pkg.sv]
// types for the optical diode signal conditioning block
`include "ods_consts.svh"

package ods_pkg;

  // focus start-up sequence
  typedef enum logic [1:0] {FOC_IDLE, FOC_ARMED, FOC_CLOSED} ods_foc_t;

  // radial level initialisation
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_FINISH} ods_cal_t;

  // whole state of the block
  typedef struct packed {
    logic [5:0]        sync1;        // first synchroniser stage
    logic [5:0]        sync2;        // second synchroniser stage
    logic [2:0]        hfSum;        // central bit sum for decoder
    logic [7:0]        winCnt;       // decimation window position
    logic [5:0][8:0]   acc;          // ones counters
    logic [5:0][8:0]   lvl;          // decimated levels
    logic              sampleValid;  // new levels present
    logic              singleMode;   // single detector focusing
    logic              focusEnable;  // allow focus start-up
    logic [3:0]        centralGain;  // central gain range code
    logic [3:0]        satGain;      // satellite gain range code
    logic [10:0]       startThr;     // focus start threshold
    logic [10:0]       dropThr;      // dropout threshold
    logic [7:0]        kp;
    logic [7:0]        ki;
    logic [7:0]        kd;
    logic [7:0]        feStart;      // error level to arm start-up
    logic [7:0]        reGain;       // unsigned Q4
    logic [7:0]        reOffset;     // signed Q4
    logic [7:0]        sumGain;      // unsigned Q4
    logic [10:0]       caLevel;      // central aperture level
    logic              focusOk;
    ods_foc_t          foc;
    logic              armSign;
    logic [7:0]        focusError;
    logic [15:0]       integ;
    logic [15:0]       focusDrive;
    logic [15:0]       radialError;
    logic              trackPos;
    logic              trackLoss;
    ods_cal_t          cal;
    logic [3:0]        calCnt;
    logic [23:0]       sumDiff;
    logic [23:0]       sumR;
    logic [23:0]       sumD;
    logic [8:0]        maxAbs;
    logic [3:0]        status;
    logic [3:0]        mask;
    logic              irq;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } ods_state_t;

endpackage

// [hdl/ods_signal_cond.sv]
// optical diode signal conditioning: decimation, focus, radial, track position
//
// Behaviour
// - one pulse-density stream per diode, five in single
// - two independent sixteen-code gain range sets
// - central gain code at index 0xA, resets 1111
// - satellite gain code at index 0xC, resets 1111
// - sum central channels as decoder HF signal
// - normal focus error: difference of two ratios
// - single mode focus error: twice first ratio
// - focus error feeds a PID stage
// - focus-ok from central level versus reference
// - focus-ok qualifies track loss, start-up, dropout
// - radial error: diff times gain plus sum times offset
// - start-up removes radial offset and scales gain
// - track sign of central sum minus weighted satellite
// - sum weighting found by own initialisation
// - focus-ok set at start threshold
// - below dropout: clear focus-ok, hold integrator
//
// Local design decision: the APB register port.
`include "ods_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ods_signal_cond (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // converter bitstreams and gain codes
  input  wire logic [5:0]  pulseDensityStream,
  output logic      [3:0]  centralGainRange,
  output logic      [3:0]  satelliteGainRange,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // servo side results
  output logic      [2:0]  hfSum,
  output logic      [7:0]  normalisedFocusError,
  output logic      [15:0] focusDrive,
  output logic      [15:0] scaledRadialError,
  output logic             trackPositionSign,
  output logic             focusOkFlag,
  output logic             trackLoss,
  output logic             irq
);

  ods_pkg::ods_state_t s;   // registered state
  ods_pkg::ods_state_t n;   // next state

  // unsigned restoring divide, all ones when den is zero
  function automatic logic [23:0] udiv(input logic [23:0] num, input logic [15:0] den);
    logic [16:0] rem;
    logic [23:0] q;
    rem = '0;
    q   = '0;
    if (den == 16'h0000)
      return 24'hFFFFFF;
    for (int i = 23; i >= 0; i--)
    begin
      rem = {rem[15:0], num[i]};
      if (rem >= {1'b0, den})
      begin
        rem  = rem - {1'b0, den};
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction

  // (a-b)/(a+b) in Q7, zero when both are zero
  function automatic logic signed [23:0] ratioQ7(input logic [8:0] a, input logic [8:0] b);
    logic [9:0]  sum;
    logic [8:0]  mag;
    logic [23:0] q;
    sum = {1'b0, a} + {1'b0, b};
    mag = (a >= b) ? (a - b) : (b - a);
    q   = udiv({8'h00, mag, 7'h00}, {6'h00, sum});
    if (sum == 10'h000)
      return 24'sh000000;
    return (a >= b) ? $signed(q) : -$signed(q);
  endfunction

  // clamp to signed 8 bits
  function automatic logic [7:0] satS8(input logic signed [23:0] v);
    if (v > 24'sh00007F)
      return 8'h7F;
    if (v < -24'sh000080)
      return 8'h80;
    return v[7:0];
  endfunction

  // clamp to signed 16 bits
  function automatic logic [15:0] satS16(input logic signed [23:0] v);
    if (v > 24'sh007FFF)
      return 16'h7FFF;
    if (v < -24'sh008000)
      return 16'h8000;
    return v[15:0];
  endfunction

  // clamp to unsigned 8 bits
  function automatic logic [7:0] satU8(input logic [23:0] v);
    return (v > 24'h0000FF) ? 8'hFF : v[7:0];
  endfunction

  // sign extend an 8 bit value
  function automatic logic signed [23:0] sx8(input logic [7:0] v);
    return $signed({{16{v[7]}}, v});
  endfunction

  // combinational working values
  logic signed [23:0] feWide;
  logic [7:0]         feNew;
  logic [10:0]        caNew;
  logic signed [23:0] diffR;
  logic [23:0]        sumRw;
  logic signed [23:0] reWide;
  logic signed [23:0] pidWide;
  logic signed [23:0] errS;
  logic [23:0]        tpiRhs;
  logic               mapped;
  logic               wrEn;
  logic [5:0]         widx;
  logic [31:0]        rdMux;
  logic [3:0]         events;
  logic [3:0]         clrBits;
  logic [23:0]        calMeanR;
  logic signed [23:0] calProd;
  logic [23:0]        calOffMag;

  // next state computation
  always_comb
  begin
    n       = s;
    events  = 4'h0;
    clrBits = 4'h0;
    widx    = paddr[7:2];
    wrEn    = 1'b0;
    rdMux   = 32'h0000_0000;

    // pins pass two flops before any use
    n.sync1 = pulseDensityStream;
    n.sync2 = s.sync1;

    // decoder HF path, d4 dropped in single mode
    n.hfSum = {2'b00, s.sync2[0]} + {2'b00, s.sync2[1]} + {2'b00, s.sync2[2]}
            + {2'b00, s.sync2[3] & ~s.singleMode};

    // decimate each stream by counting ones per window
    n.winCnt      = s.winCnt + 8'h01;
    n.sampleValid = 1'b0;
    for (int c = 0; c < `ODS_NUM_CH; c++)
    begin
      if (s.winCnt == `ODS_WIN_LAST)
      begin
        n.lvl[c] = s.acc[c] + {8'h00, s.sync2[c]};
        n.acc[c] = '0;
      end
      else
        n.acc[c] = s.acc[c] + {8'h00, s.sync2[c]};
    end
    if (s.winCnt == `ODS_WIN_LAST)
      n.sampleValid = 1'b1;
    // fourth converter (d4) idle in single mode
    if (s.singleMode)
      n.lvl[3] = '0;

    // focus error, one of two formulas
    if (s.singleMode)
      feWide = ratioQ7(s.lvl[0], s.lvl[1]) <<< 1;
    else
      feWide = ratioQ7(s.lvl[0], s.lvl[1]) - ratioQ7(s.lvl[2], s.lvl[3]);
    feNew = satS8(feWide);

    // central aperture level
    caNew = {2'b00, s.lvl[0]} + {2'b00, s.lvl[1]} + {2'b00, s.lvl[2]} + {2'b00, s.lvl[3]};

    // radial error, Q4 coefficients
    diffR  = $signed({15'h0000, s.lvl[4]}) - $signed({15'h0000, s.lvl[5]});
    sumRw  = {15'h0000, s.lvl[4]} + {15'h0000, s.lvl[5]};
    reWide = (diffR * $signed({16'h0000, s.reGain})
            + $signed(sumRw) * sx8(s.reOffset)) >>> 4;

    // pid terms on the fresh error
    errS    = sx8(feNew);
    pidWide = errS * $signed({16'h0000, s.kp}) + sx8(s.integ[15:8]) * 24'sd256
            + $signed({16'h0000, s.integ[7:0]})
            + (errS - sx8(s.focusError)) * $signed({16'h0000, s.kd});

    // track position right side
    tpiRhs = sumRw * {16'h0000, s.sumGain};

    // calibration results
    calMeanR  = s.sumR >> `ODS_CAL_SHIFT;
    calProd   = ($signed(s.sumDiff) >>> `ODS_CAL_SHIFT) * $signed({16'h0000, n.reGain});
    calOffMag = udiv(calProd[23] ? 24'(-calProd) : 24'(calProd), calMeanR[15:0]);

    // per sample processing
    if (s.sampleValid)
    begin
      n.focusError  = feNew;
      n.caLevel     = caNew;
      n.radialError = satS16(reWide);
      n.trackPos    = ({caNew, 4'h0} >= tpiRhs[14:0]) && (tpiRhs[23:15] == 9'h000);
      // hysteresis: start threshold sets, dropout clears
      if (caNew >= s.startThr)
        n.focusOk = 1'b1;
      else if (caNew < s.dropThr)
        n.focusOk = 1'b0;
      // track loss only trusted while focus is good
      n.trackLoss = ~n.focusOk | ~n.trackPos;

      // focus start-up: arm on error level, close on zero crossing
      unique case (s.foc)
        ods_pkg::FOC_IDLE:
        begin
          if (s.focusEnable && n.focusOk && (errS >= sx8(s.feStart) || -errS >= sx8(s.feStart)))
          begin
            n.foc     = ods_pkg::FOC_ARMED;
            n.armSign = feNew[7];
          end
        end
        ods_pkg::FOC_ARMED:
        begin
          if (!n.focusOk || !s.focusEnable)
            n.foc = ods_pkg::FOC_IDLE;
          else if (feNew[7] != s.armSign)
            n.foc = ods_pkg::FOC_CLOSED;
        end
        ods_pkg::FOC_CLOSED:
        begin
          if (!s.focusEnable)
            n.foc = ods_pkg::FOC_IDLE;
        end
      endcase

      // pid runs only with the loop closed
      if (s.foc == ods_pkg::FOC_CLOSED)
      begin
        n.focusDrive = satS16(pidWide);
        // integrator frozen through a dropout
        if (n.focusOk)
          n.integ = satS16($signed({{8{s.integ[15]}}, s.integ}) + errS * $signed({16'h0000, s.ki}));
        else
          n.integ = s.integ;
      end
      else
      begin
        n.focusDrive = '0;
        n.integ      = '0;
      end

      // event detection
      events[`ODS_EV_FOK_RISE] = n.focusOk & ~s.focusOk;
      events[`ODS_EV_DROPOUT]  = ~n.focusOk & s.focusOk;
      events[`ODS_EV_TRK_LOSS] = n.trackLoss & ~s.trackLoss;
    end

    // level initialisation: gather sixteen samples
    unique case (s.cal)
      ods_pkg::CAL_IDLE: ;
      ods_pkg::CAL_RUN:
      begin
        if (s.sampleValid)
        begin
          n.sumDiff = s.sumDiff + diffR;
          n.sumR    = s.sumR + sumRw;
          n.sumD    = s.sumD + {13'h0000, caNew};
          if ((diffR[23] ? 24'(-diffR) : 24'(diffR)) > {15'h0000, s.maxAbs})
            n.maxAbs = diffR[23] ? 9'(-diffR) : 9'(diffR);
          n.calCnt = s.calCnt + 4'h1;
          if (s.calCnt == `ODS_CAL_LAST)
            n.cal = ods_pkg::CAL_FINISH;
        end
      end
      ods_pkg::CAL_FINISH:
      begin
        // gain scales peak to target, offset cancels mean
        n.reGain   = satU8(udiv(`ODS_RE_TARGET << 4, {7'h00, s.maxAbs}));
        n.reOffset = (calOffMag > 24'h00007F) ? (calProd[23] ? 8'h7F : 8'h81)
                   : (calProd[23] ? calOffMag[7:0] : 8'(-calOffMag[7:0]));
        n.sumGain  = satU8(udiv((s.sumD >> `ODS_CAL_SHIFT) << 4, calMeanR[15:0]));
        n.cal      = ods_pkg::CAL_IDLE;
        events[`ODS_EV_CAL_DONE] = 1'b1;
      end
      default:
        n.cal = ods_pkg::CAL_IDLE;
    endcase

    // apb decode: aligned words only
    unique case (widx)
      `ODS_IDX_CTRL, `ODS_IDX_STATUS, `ODS_IDX_MASK, `ODS_IDX_START_THR,
      `ODS_IDX_DROP_THR, `ODS_IDX_RADIAL_GAIN_COEFF, `ODS_IDX_RADIAL_OFFSET_COEFF, `ODS_IDX_SUM_GAIN,
      `ODS_IDX_FOCUS_RD, `ODS_IDX_RADIAL_RD, `ODS_IDX_CGAIN, `ODS_IDX_PID,
      `ODS_IDX_SGAIN, `ODS_IDX_DRIVE_RD:
        mapped = (paddr[1:0] == 2'b00);
      default:
        mapped = 1'b0;
    endcase

    // read mux
    unique case (widx)
      `ODS_IDX_CTRL:      rdMux = {28'h0, (s.cal != ods_pkg::CAL_IDLE), s.focusEnable,
                                   1'b0, s.singleMode};
      `ODS_IDX_STATUS:    rdMux = {28'h0, s.status};
      `ODS_IDX_MASK:      rdMux = {28'h0, s.mask};
      `ODS_IDX_START_THR: rdMux = {21'h0, s.startThr};
      `ODS_IDX_DROP_THR:  rdMux = {21'h0, s.dropThr};
      `ODS_IDX_RADIAL_GAIN_COEFF:   rdMux = {24'h0, s.reGain};
      `ODS_IDX_RADIAL_OFFSET_COEFF: rdMux = {24'h0, s.reOffset};
      `ODS_IDX_SUM_GAIN:  rdMux = {24'h0, s.sumGain};
      `ODS_IDX_FOCUS_RD:  rdMux = {2'h0, s.foc, s.focusOk, s.caLevel, 8'h00, s.focusError};
      `ODS_IDX_RADIAL_RD: rdMux = {13'h0, s.trackLoss, s.focusOk, s.trackPos, s.radialError};
      `ODS_IDX_CGAIN:     rdMux = {28'h0, s.centralGain};
      `ODS_IDX_PID:       rdMux = {s.feStart, s.kd, s.ki, s.kp};
      `ODS_IDX_SGAIN:     rdMux = {28'h0, s.satGain};
      `ODS_IDX_DRIVE_RD:  rdMux = {16'h0, s.focusDrive};
      default:            rdMux = 32'h0000_0000;
    endcase

    // answer one cycle after setup
    n.pready  = psel & ~penable;
    n.pslverr = psel & ~penable & ~mapped;
    n.prdata  = (psel & ~penable & ~pwrite & mapped) ? rdMux : 32'h0000_0000;
    wrEn      = psel & penable & s.pready & pwrite & mapped;

    // register writes
    if (wrEn)
    begin
      unique case (widx)
        `ODS_IDX_CTRL:
        begin
          n.singleMode  = pwdata[`ODS_CTRL_SINGLE];
          n.focusEnable = pwdata[`ODS_CTRL_FOCUS_EN];
          // a start while running is ignored
          if (pwdata[`ODS_CTRL_CAL] && s.cal == ods_pkg::CAL_IDLE)
          begin
            n.cal     = ods_pkg::CAL_RUN;
            n.calCnt  = '0;
            n.sumDiff = '0;
            n.sumR    = '0;
            n.sumD    = '0;
            n.maxAbs  = '0;
          end
        end
        `ODS_IDX_STATUS:    clrBits       = pwdata[3:0];
        `ODS_IDX_MASK:      n.mask        = pwdata[3:0];
        `ODS_IDX_START_THR: n.startThr    = pwdata[10:0];
        `ODS_IDX_DROP_THR:  n.dropThr     = pwdata[10:0];
        `ODS_IDX_RADIAL_GAIN_COEFF:   n.reGain      = pwdata[7:0];
        `ODS_IDX_RADIAL_OFFSET_COEFF: n.reOffset    = pwdata[7:0];
        `ODS_IDX_CGAIN:     n.centralGain = pwdata[3:0];
        `ODS_IDX_PID:       {n.feStart, n.kd, n.ki, n.kp} = pwdata;
        `ODS_IDX_SGAIN:     n.satGain     = pwdata[3:0];
        default: ;
      endcase
    end

    // sticky status, a new event beats the clear
    n.status = (s.status & ~clrBits) | events;
    n.irq    = |(n.status & n.mask);
  end

  // state register with synchronous reset
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      s             <= '0;
      s.centralGain <= `ODS_RST_GAIN;
      s.satGain     <= `ODS_RST_GAIN;
      s.startThr    <= `ODS_RST_START_THR;
      s.dropThr     <= `ODS_RST_DROP_THR;
      s.reGain      <= `ODS_RST_RADIAL_GAIN_COEFF;
      s.reOffset    <= `ODS_RST_RADIAL_OFFSET_COEFF;
      s.sumGain     <= `ODS_RST_SUM_GAIN;
      s.kp          <= `ODS_RST_KP;
      s.ki          <= `ODS_RST_KI;
      s.kd          <= `ODS_RST_KD;
      s.feStart     <= `ODS_RST_FE_START;
      s.foc         <= ods_pkg::FOC_IDLE;
      s.cal         <= ods_pkg::CAL_IDLE;
      s.trackLoss   <= 1'b1;
    end
    else
      s <= n;
  end

  // outputs straight from the state flops
  assign centralGainRange     = s.centralGain;
  assign satelliteGainRange   = s.satGain;
  assign prdata               = s.prdata;
  assign pready               = s.pready;
  assign pslverr              = s.pslverr;
  assign hfSum                = s.hfSum;
  assign normalisedFocusError = s.focusError;
  assign focusDrive           = s.focusDrive;
  assign scaledRadialError    = s.radialError;
  assign trackPositionSign    = s.trackPos;
  assign focusOkFlag          = s.focusOk;
  assign trackLoss            = s.trackLoss;
  assign irq                  = s.irq;

endmodule // ods_signal_cond

`default_nettype wire

// [testbench/ods_diode_model.sv]
// pickup diode and converter model: six pulse-density streams
`timescale 1ns/1ps
`default_nettype none

module ods_diode_model (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // ones per 256 cycles, order d1 d2 d3 d4 r1 r2
  input  wire logic [5:0][8:0] density,
  // converter bitstreams
  output var  logic [5:0]      pulseDensityStream
);
  logic [5:0][7:0] phase; // phase accumulators

  // carry out is the bit: any 256-cycle window holds exactly density ones
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (!reset_n)
      begin
        phase[i] <= 8'h00;
        pulseDensityStream[i] <= 1'b0;
      end
      else
      begin
        {pulseDensityStream[i], phase[i]} <= {1'b0, phase[i]} + density[i];
      end
    end
  end
endmodule // ods_diode_model
`default_nettype wire

// [testbench/ods_signal_cond_monitor.sv]
// port checker for the diode signal conditioning block
`timescale 1ns/1ps
`default_nettype none

module ods_signal_cond_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // results
  input wire logic [3:0]  centralGainRange,
  input wire logic [3:0]  satelliteGainRange,
  input wire logic [2:0]  hfSum,
  input wire logic [5:0]  pulseDensityStream,
  input wire logic [7:0]  normalisedFocusError,
  input wire logic        focusOkFlag,
  input wire logic        trackPositionSign,
  input wire logic        trackLoss
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // write completing at this edge
  wire logic wrDone = psel && penable && pready && pwrite;

  // bus handshake: one access cycle, errors and data only then
  apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable)) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("idle data");
  // gain codes: reset, write, hold
  gain_reset_a: assert property ($rose(reset_n) |-> centralGainRange == 4'hF && satelliteGainRange == 4'hF)
    else $error("gain reset");
  cgain_write_a: assert property (wrDone && paddr == 8'h28 |=> centralGainRange == $past(pwdata[3:0]))
    else $error("central gain write");
  sgain_write_a: assert property (wrDone && paddr == 8'h30 |=> satelliteGainRange == $past(pwdata[3:0]))
    else $error("satellite gain write");
  cgain_hold_a: assert property (!(wrDone && paddr == 8'h28) |=> $stable(centralGainRange))
    else $error("central gain moved");
  sgain_hold_a: assert property (!(wrDone && paddr == 8'h30) |=> $stable(satelliteGainRange))
    else $error("satellite gain moved");
  // track loss follows the two flags once they settle
  trk_loss_a: assert property (($stable(focusOkFlag) && $stable(trackPositionSign))[*2] |->
    trackLoss == (!focusOkFlag || !trackPositionSign)) else $error("track loss");
  // focus error holds for eight cycles after each move
  fe_hold_a: assert property ($changed(normalisedFocusError) |=> $stable(normalisedFocusError)[*8])
    else $error("focus error glitch");
  hf_bound_a: assert property (hfSum >= $countones($past(pulseDensityStream[2:0], 3)) &&
    hfSum <= $countones($past(pulseDensityStream[3:0], 3))) else $error("hf sum range");

  // main scenarios reached
  cover property (wrDone && pslverr);
  cover property ($rose(focusOkFlag));
  cover property ($fell(focusOkFlag));
  cover property ($fell(trackLoss));
endmodule // ods_signal_cond_monitor

bind ods_signal_cond ods_signal_cond_monitor u_monitor (.mclk, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .centralGainRange, .satelliteGainRange,
  .hfSum, .pulseDensityStream, .normalisedFocusError, .focusOkFlag, .trackPositionSign, .trackLoss);
`default_nettype wire

// [testbench/ods_signal_cond_tb.sv]
// self-checking bench for the diode signal conditioning block
`timescale 1ns/1ps
`default_nettype none

module ods_signal_cond_tb;
  logic            mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic            trackPositionSign, focusOkFlag, trackLoss, irq;
  logic [7:0]      paddr, normalisedFocusError;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      centralGainRange, satelliteGainRange;
  logic [2:0]      hfSum;
  logic [15:0]     focusDrive, scaledRadialError;
  logic [5:0]      pulseDensityStream;
  logic [5:0][8:0] density;
  int              errTotal = 0, comparisons = 0, cycles = 0;
  // reset value table: gains, start threshold, sum weight, radial gain
  logic [7:0]      ra [5] = '{8'h28, 8'h30, 8'h0C, 8'h1C, 8'h14};
  logic [31:0]     rv [5] = '{32'h0000_000F, 32'h0000_000F, 32'h0000_0200, 32'h0000_0020,
                              32'h0000_0010};

  ods_signal_cond DUT (.mclk, .reset_n, .pulseDensityStream, .centralGainRange,
    .satelliteGainRange, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hfSum, .normalisedFocusError, .focusDrive, .scaledRadialError, .trackPositionSign,
    .focusOkFlag, .trackLoss, .irq);
  ods_diode_model u_diodes (.mclk, .reset_n, .density, .pulseDensityStream);

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // verdict, the single exit of the run
  task automatic final_report();
    if (errTotal == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; starts on a fresh edge so psel is never driven twice at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
  endtask

  // new diode levels, then three windows so a full window has passed
  task automatic setd(input logic [8:0] d1, d2, d3, d4, r1, r2);
    @(posedge mclk);
    density <= {r2, r1, d4, d3, d2, d1};
    repeat (768) @(posedge mclk);
  endtask

  // hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errTotal++;
      final_report();
    end
  end

  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    density = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++)
      rchk("reset value", ra[i], rv[i]);
    // every code of both sets, set independently
    for (int c = 0; c < 16; c++)
    begin
      xfer(1'b1, 8'h28, c);
      xfer(1'b1, 8'h30, 15 - c);
      @(posedge mclk);
      check("central gain", centralGainRange, c);
      check("satellite gain", satelliteGainRange, 15 - c);
    end
    // refused accesses and a read-only weight
    rchk("unmapped", 8'hFC, 32'h0000_0000);
    check("unmapped err", err, 1'b1);
    xfer(1'b1, 8'h29, 32'h0000_0003);
    check("misaligned err", err, 1'b1);
    rchk("central kept", 8'h28, 32'h0000_000F);
    xfer(1'b1, 8'h1C, 32'h0000_0055);
    rchk("sum weight ro", 8'h1C, 32'h0000_0020);
    // reset in mid-run brings gains back
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    check("satellite reset", satelliteGainRange, 4'hF);
    xfer(1'b1, 8'h08, 32'h0000_000F);
    // level 512 reaches the start threshold
    setd(9'h0A0, 9'h060, 9'h080, 9'h080, 9'h0C8, 9'h064);
    check("focus error", normalisedFocusError, 8'h20);
    rchk("focus read", 8'h20, 32'h0A00_0020);
    check("radial", scaledRadialError, 16'h0064);
    check("track sign", trackPositionSign, 1'b0);
    check("track loss", trackLoss, 1'b1);
    check("irq", irq, 1'b1);
    // offset coefficient one, balanced satellites
    xfer(1'b1, 8'h18, 32'h0000_0010);
    xfer(1'b1, 8'h00, 32'h0000_0004);
    setd(9'h0A0, 9'h060, 9'h080, 9'h080, 9'h064, 9'h064);
    check("radial offset", scaledRadialError, 16'h00C8);
    check("track sign", trackPositionSign, 1'b1);
    check("track loss", trackLoss, 1'b0);
    // armed on a positive error, closes when it turns negative
    setd(9'h060, 9'h0A0, 9'h080, 9'h080, 9'h064, 9'h064);
    rchk("loop closed", 8'h20, 32'h2A00_00E0);
    check("drive sign", focusDrive[15], 1'b1);
    // ratios at plus and minus one half, difference saturates
    setd(9'h0C0, 9'h040, 9'h040, 9'h0C0, 9'h064, 9'h064);
    check("saturated", normalisedFocusError, 8'h7F);
    // single detector ignores the second pair
    xfer(1'b1, 8'h00, 32'h0000_0001);
    setd(9'h0A0, 9'h060, 9'h040, 9'h0C0, 9'h064, 9'h064);
    check("single mode", normalisedFocusError, 8'h40);
    check("focus ok kept", focusOkFlag, 1'b1);
    check("drive off", focusDrive, 16'h0000);
    // all dark: zero denominators, dropout
    xfer(1'b1, 8'h00, 32'h0000_0000);
    setd(9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000);
    check("zero denom", normalisedFocusError, 8'h00);
    check("dropout", focusOkFlag, 1'b0);
    rchk("status", 8'h04, 32'h0000_000B);
    xfer(1'b1, 8'h08, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    check("irq masked", irq, 1'b0);
    xfer(1'b1, 8'h08, 32'h0000_000F);
    xfer(1'b1, 8'h04, 32'h0000_000B);
    repeat (3) @(posedge mclk);
    check("irq cleared", irq, 1'b0);
    rchk("status clear", 8'h04, 32'h0000_0000);
    // level initialisation finds the weights itself
    setd(9'h080, 9'h080, 9'h080, 9'h080, 9'h040, 9'h040);
    xfer(1'b1, 8'h00, 32'h0000_0002);
    do
    begin
      repeat (256) @(posedge mclk);
      xfer(1'b0, 8'h04, 32'h0000_0000);
    end
    while (rd[2] !== 1'b1);
    rchk("sum weight", 8'h1C, 32'h0000_0040);
    rchk("radial gain", 8'h14, 32'h0000_00FF);
    rchk("radial offset", 8'h18, 32'h0000_0000);
    rchk("ctrl idle", 8'h00, 32'h0000_0000);
    final_report();
  end
endmodule // ods_signal_cond_tb
`default_nettype wire
